/* File: hdl/delay_ctrl_pkg.sv */
// constants, field layout and types of the delay line control block
package delay_ctrl_pkg;

    localparam int        NUM_CH          = 5;
    localparam int        DATA_W          = 8;
    localparam int        DELAY_W         = 6;
    localparam int        STRAP_W         = 4;
    localparam int        SEL_W           = 3;
    localparam int        MODE_W          = 2;

    // register selects (low address bits)
    localparam logic [2:0] SEL_CH0        = 3'h0;
    localparam logic [2:0] SEL_CH3        = 3'h3;
    localparam logic [2:0] SEL_CLK_CH     = 3'h4;
    localparam logic [2:0] SEL_GLOBAL     = 3'h5;

    // field positions
    localparam int        CH_DELAY_LSB    = 0;
    localparam int        CH_ENABLE_BIT   = 6;
    localparam int        GL_MODE_LSB     = 0;
    localparam int        GL_RESYNC_BIT   = 6;
    localparam int        GL_CHIP_RST_BIT = 7;

    // reset values
    localparam logic [5:0] DELAY_RESET    = 6'h00;
    localparam logic       ENABLE_RESET   = 1'b0;

    // clock mode encodings
    localparam logic [1:0] MODE_40MHZ     = 2'h0;
    localparam logic [1:0] MODE_80MHZ     = 2'h1;
    localparam logic [1:0] MODE_32MHZ     = 2'h2;
    localparam logic [1:0] MODE_64MHZ     = 2'h3;

    // analog step of one delay code unit
    localparam int        DELAY_STEP_PS   = 500;

    // timing
    localparam int        CLK_PERIOD_NS   = 100;
    localparam int        RESYNC_TIME_NS  = 1000;
    localparam int        RESYNC_CYCLES   = (RESYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // i2c bit counter
    localparam logic [3:0] BIT_LAST       = 4'h7;
    localparam logic [3:0] BIT_ACK        = 4'h8;

    typedef enum logic [1:0] {
        LS_IDLE,
        LS_ADDR,
        LS_WDATA,
        LS_RDATA
    } link_state_t;

endpackage

/* File: hdl/bit_sync.sv */
// two flip-flop synchroniser for level signals
`timescale 1ns/100ps
module bit_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] q_next;

    always_comb
    begin
        meta_next = d_i;
        q_next    = meta_reg;
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            meta_reg <= '0;
            q_o      <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            q_o      <= q_next;
        end
    end
endmodule

/* File: hdl/pulse_stretch.sv */
// stretches a one-cycle trigger into a pulse of fixed length
`timescale 1ns/100ps
module pulse_stretch #(
    parameter int unsigned CYCLES = 10
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    input  wire logic trig_i,
    output logic      pulse_o
);
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic       pulse_next;

    if (CYCLES < 1 || CYCLES > 255)
    begin : g_bad_cycles
        $error("pulse_stretch: CYCLES must lie in 1..255");
    end

    // a new trigger restarts the full length
    always_comb
    begin
        cnt_next = cnt_reg;
        if (trig_i)
            cnt_next = CYCLES[7:0];
        else if (cnt_reg != 8'h00)
            cnt_next = cnt_reg - 8'h01;
        pulse_next = (cnt_next != 8'h00);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_reg <= 8'h00;
            pulse_o <= 1'b0;
        end
        else
        begin
            cnt_reg <= cnt_next;
            pulse_o <= pulse_next;
        end
    end
endmodule

/* File: hdl/delay_line_i2c_control.sv */
// i2c target and control registers of the five-channel delay line
`timescale 1ns/100ps
module delay_line_i2c_control #(
    parameter int unsigned RESYNC_CYCLES = delay_ctrl_pkg::RESYNC_CYCLES
) (
    input  wire logic                                clk_i,
    input  wire logic                                rst_b_i,
    input  wire logic                                scl_i,
    input  wire logic                                sda_i,
    output logic                                     sda_o,
    output logic                                     sda_oe_b_o,
    input  wire logic [delay_ctrl_pkg::STRAP_W-1:0]  chip_address_straps_i,
    input  wire logic                                buffer_style_select_i,
    output logic [delay_ctrl_pkg::NUM_CH-1:0][delay_ctrl_pkg::DELAY_W-1:0] delay_code_o,
    output logic [delay_ctrl_pkg::NUM_CH-1:0]        chan_enable_o,
    output logic [delay_ctrl_pkg::MODE_W-1:0]        clk_mode_o,
    output logic                                     loop_resync_o,
    output logic                                     buffer_diff_o
);
    import delay_ctrl_pkg::*;

    // clock domain state
    logic [NUM_CH-1:0]              ch_en_reg;
    logic [NUM_CH-1:0]              ch_en_next;
    logic [NUM_CH-1:0][DELAY_W-1:0] ch_delay_reg;
    logic [NUM_CH-1:0][DELAY_W-1:0] ch_delay_next;
    logic [MODE_W-1:0]              mode_reg;
    logic [MODE_W-1:0]              mode_next;
    logic                           wr_tgl_s;
    logic                           wr_tgl_d_reg;
    logic                           wr_commit;
    logic                           soft_rst;
    logic                           resync_req;
    // mode powers up unknown; its hold check waits for the first mode write
    logic                           mode_set_reg;
    logic                           mode_set_next;

    // link (scl) domain state
    logic                           start_tgl_reg;
    logic                           start_tgl_next;
    logic                           start_seen_reg;
    logic                           start_seen_next;
    link_state_t                    st_reg;
    link_state_t                    st_next;
    logic [3:0]                     cnt_reg;
    logic [3:0]                     cnt_next;
    logic [DATA_W-1:0]              shift_reg;
    logic [DATA_W-1:0]              shift_next;
    logic [SEL_W-1:0]               sel_reg;
    logic [SEL_W-1:0]               sel_next;
    logic                           rw_reg;
    logic                           rw_next;
    logic                           addr_ok_reg;
    logic                           addr_ok_next;
    logic [DATA_W-1:0]              rd_byte_reg;
    logic [DATA_W-1:0]              rd_byte_next;
    logic [DATA_W-1:0]              wr_data_reg;
    logic [DATA_W-1:0]              wr_data_next;
    logic                           wr_tgl_reg;
    logic                           wr_tgl_next;
    logic [STRAP_W-1:0]             straps_s;
    logic                           new_start;
    logic [DATA_W-1:0]              byte_in;
    logic                           drive_low;
    logic                           sda_out_next;

    // register read view; unused selects and bits give zero
    function automatic logic [DATA_W-1:0] reg_read(
        input logic [SEL_W-1:0]               sel,
        input logic [NUM_CH-1:0]              en,
        input logic [NUM_CH-1:0][DELAY_W-1:0] dly,
        input logic [MODE_W-1:0]              mode
    );
        logic [DATA_W-1:0] v;
        v = 8'h00;
        if (sel < SEL_GLOBAL)
            v = {1'b0, en[sel], dly[sel]};
        else if (sel == SEL_GLOBAL)
            v = {6'h00, mode};
        return v;
    endfunction

    // start detector: sda falling while scl high; clocked by sda itself since
    // scl gives no edge during a start condition
    always_comb
    begin
        start_tgl_next = scl_i ? ~start_tgl_reg : start_tgl_reg;
    end

    always_ff @(negedge sda_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            start_tgl_reg <= 1'b0;
        else
            start_tgl_reg <= start_tgl_next;
    end

    // straps are static pins; synchronised on the link clock before the compare
    bit_sync #(
        .W (STRAP_W)
    ) u_strap_sync (
        .clk_i   (scl_i),
        .rst_b_i (rst_b_i),
        .d_i     (chip_address_straps_i),
        .q_o     (straps_s)
    );

    // the start toggle settles during scl high, well before the next rising edge
    always_comb
    begin
        new_start       = (start_tgl_reg != start_seen_reg);
        byte_in         = {shift_reg[6:0], sda_i};
        start_seen_next = start_tgl_reg;
        st_next         = st_reg;
        cnt_next        = cnt_reg;
        shift_next      = shift_reg;
        sel_next        = sel_reg;
        rw_next         = rw_reg;
        addr_ok_next    = addr_ok_reg;
        rd_byte_next    = rd_byte_reg;
        wr_data_next    = wr_data_reg;
        wr_tgl_next     = wr_tgl_reg;
        if (new_start)
        begin
            st_next      = LS_ADDR;
            cnt_next     = 4'h1;
            shift_next   = {7'h00, sda_i};
            addr_ok_next = 1'b0;
        end
        else
        begin
            case (st_reg)
                LS_ADDR:
                begin
                    if (cnt_reg == BIT_ACK)
                    begin
                        addr_ok_next = 1'b0;
                        cnt_next     = 4'h0;
                        if (rw_reg)
                        begin
                            st_next      = LS_RDATA;
                            rd_byte_next = reg_read(sel_reg, ch_en_reg, ch_delay_reg, mode_reg);
                        end
                        else
                            st_next = LS_WDATA;
                    end
                    else
                    begin
                        shift_next = byte_in;
                        cnt_next   = cnt_reg + 4'h1;
                        if (cnt_reg == BIT_LAST)
                        begin
                            if (byte_in[7:4] == straps_s)
                            begin
                                addr_ok_next = 1'b1;
                                sel_next     = byte_in[3:1];
                                rw_next      = byte_in[0];
                            end
                            else
                                st_next = LS_IDLE;
                        end
                    end
                end
                LS_WDATA:
                begin
                    if (cnt_reg == BIT_ACK)
                        cnt_next = 4'h0;
                    else
                    begin
                        shift_next = byte_in;
                        cnt_next   = cnt_reg + 4'h1;
                        if (cnt_reg == BIT_LAST)
                        begin
                            wr_data_next = byte_in;
                            wr_tgl_next  = ~wr_tgl_reg;
                        end
                    end
                end
                LS_RDATA:
                begin
                    if (cnt_reg == BIT_ACK)
                    begin
                        // controller nack ends the read
                        if (sda_i)
                            st_next = LS_IDLE;
                        else
                        begin
                            cnt_next     = 4'h0;
                            rd_byte_next = reg_read(sel_reg, ch_en_reg, ch_delay_reg, mode_reg);
                        end
                    end
                    else
                        cnt_next = cnt_reg + 4'h1;
                end
                default:
                begin
                    st_next = LS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge scl_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            start_seen_reg <= 1'b0;
            st_reg         <= LS_IDLE;
            cnt_reg        <= 4'h0;
            shift_reg      <= 8'h00;
            sel_reg        <= 3'h0;
            rw_reg         <= 1'b0;
            addr_ok_reg    <= 1'b0;
            rd_byte_reg    <= 8'h00;
            wr_data_reg    <= 8'h00;
            wr_tgl_reg     <= 1'b0;
        end
        else
        begin
            start_seen_reg <= start_seen_next;
            st_reg         <= st_next;
            cnt_reg        <= cnt_next;
            shift_reg      <= shift_next;
            sel_reg        <= sel_next;
            rw_reg         <= rw_next;
            addr_ok_reg    <= addr_ok_next;
            rd_byte_reg    <= rd_byte_next;
            wr_data_reg    <= wr_data_next;
            wr_tgl_reg     <= wr_tgl_next;
        end
    end

    // sda changes only while scl is low, so it is updated on the falling edge
    always_comb
    begin
        drive_low = (((st_reg == LS_ADDR) && addr_ok_reg) || (st_reg == LS_WDATA))
                    && (cnt_reg == BIT_ACK);
        if ((st_reg == LS_RDATA) && (cnt_reg < BIT_ACK))
            drive_low = !rd_byte_reg[3'h7 - cnt_reg[2:0]];
        sda_out_next = 1'b0;
    end

    always_ff @(negedge scl_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sda_oe_b_o <= 1'b1;
            sda_o      <= 1'b0;
        end
        else
        begin
            sda_oe_b_o <= !drive_low;
            sda_o      <= sda_out_next;
        end
    end

    // write event crosses as a toggle; data and select stay put until the next
    // byte, many link cycles after the clock side has taken them
    bit_sync #(
        .W (1)
    ) u_wr_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (wr_tgl_reg),
        .q_o     (wr_tgl_s)
    );

    bit_sync #(
        .W (1)
    ) u_style_sync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .d_i     (buffer_style_select_i),
        .q_o     (buffer_diff_o)
    );

    always_comb
    begin
        wr_commit  = wr_tgl_s ^ wr_tgl_d_reg;
        soft_rst   = wr_commit && (sel_reg == SEL_GLOBAL) && wr_data_reg[GL_CHIP_RST_BIT];
        resync_req = wr_commit && (sel_reg == SEL_GLOBAL) && wr_data_reg[GL_RESYNC_BIT];
        ch_en_next    = ch_en_reg;
        ch_delay_next = ch_delay_reg;
        mode_next     = mode_reg;
        mode_set_next = mode_set_reg || (wr_commit && (sel_reg == SEL_GLOBAL));
        if (wr_commit)
        begin
            if (sel_reg < SEL_GLOBAL)
            begin
                ch_en_next[sel_reg]    = wr_data_reg[CH_ENABLE_BIT];
                ch_delay_next[sel_reg] = wr_data_reg[DELAY_W-1:CH_DELAY_LSB];
            end
            else if (sel_reg == SEL_GLOBAL)
                mode_next = wr_data_reg[GL_MODE_LSB+1:GL_MODE_LSB];
        end
        // chip reset over the bus clears channels but not the clock mode
        if (soft_rst)
        begin
            ch_en_next    = {NUM_CH{ENABLE_RESET}};
            ch_delay_next = {NUM_CH{DELAY_RESET}};
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            wr_tgl_d_reg <= 1'b0;
            mode_set_reg <= 1'b0;
            ch_en_reg    <= {NUM_CH{ENABLE_RESET}};
            ch_delay_reg <= {NUM_CH{DELAY_RESET}};
        end
        else
        begin
            wr_tgl_d_reg <= wr_tgl_s;
            mode_set_reg <= mode_set_next;
            ch_en_reg    <= ch_en_next;
            ch_delay_reg <= ch_delay_next;
        end
    end

    // no reset term: the mode survives pin and bus resets, undefined at power-up
    always_ff @(posedge clk_i)
    begin
        mode_reg <= mode_next;
    end

    // resync is also part of a bus chip reset; the bit itself is never stored
    pulse_stretch #(
        .CYCLES (RESYNC_CYCLES)
    ) u_resync (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .trig_i  (resync_req || soft_rst),
        .pulse_o (loop_resync_o)
    );

    // each code step is one half-nanosecond tap of the replica line
    assign delay_code_o  = ch_delay_reg;
    assign chan_enable_o = ch_en_reg;
    assign clk_mode_o    = mode_reg;

    sequence s_resync_write;
        wr_commit && (sel_reg == SEL_GLOBAL) && wr_data_reg[GL_RESYNC_BIT];
    endsequence

    sequence s_resync_hold;
        loop_resync_o [*8];
    endsequence

    AST_STRAP_MATCH:
        assert property (@(posedge scl_i) disable iff (!rst_b_i)
            $rose(addr_ok_reg) |-> (shift_reg[7:4] == straps_s))
        else $error("address acknowledged without strap match");

    AST_UNUSED_IGNORED:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            (wr_commit && (sel_reg > SEL_GLOBAL)) |=>
            ($stable(ch_en_reg) && $stable(ch_delay_reg) && $stable(mode_reg)))
        else $error("write to unused select changed state");

    AST_CHANNEL_WRITE:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            (wr_commit && (sel_reg < SEL_GLOBAL) && !soft_rst) |=>
            (delay_code_o[$past(sel_reg)] == $past(wr_data_reg[5:0])))
        else $error("channel delay code not taken");

    AST_CHANNEL_ENABLE:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            (wr_commit && (sel_reg < SEL_GLOBAL)) |=>
            (chan_enable_o[$past(sel_reg)] == $past(wr_data_reg[CH_ENABLE_BIT])))
        else $error("channel enable not taken");

    AST_CHIP_SOFT_RESET:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            soft_rst |=> ((chan_enable_o == '0) && (delay_code_o == '0)))
        else $error("bus chip reset left a channel set");

    AST_MODE_WRITE:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            (wr_commit && (sel_reg == SEL_GLOBAL)) |=>
            (clk_mode_o == $past(wr_data_reg[1:0])))
        else $error("clock mode not taken");

    AST_MODE_HOLD:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            (!wr_commit && mode_set_reg) |=> $stable(clk_mode_o))
        else $error("clock mode changed without a write");

    AST_RESYNC_PULSE:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            s_resync_write |=> s_resync_hold)
        else $error("loop resync pulse missing or short");

    AST_RESYNC_READS_ZERO:
        assert property (@(posedge scl_i) disable iff (!rst_b_i)
            ((st_reg == LS_RDATA) && (sel_reg == SEL_GLOBAL)) |-> !rd_byte_reg[GL_RESYNC_BIT])
        else $error("resync bit read as one");

    AST_BUFFER_STYLE:
        assert property (@(posedge clk_i) disable iff (!rst_b_i)
            $rose(buffer_style_select_i) |-> ##[1:3] buffer_diff_o)
        else $error("buffer style not followed");

endmodule

/* File: verif/i2c_master_model.sv */
// behavioural i2c controller that drives the target's serial link
`timescale 1ns/100ps
module i2c_master_model (
    output logic       scl_o,
    output logic       sda_low_o,
    input  wire logic  sda_i,
    output logic [7:0] rd_data_o,
    output logic       rd_ev_o
);
    localparam int HALF = 32;
    // scl stands high between frames; released sda goes high through the pull-up
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
        rd_data_o = 8'h00;
        rd_ev_o = 1'b0;
    end
    task automatic start();
        #HALF sda_low_o = 1'b1;
        #HALF scl_o = 1'b0;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #(HALF/2) sda_low_o = !b[i];
            #(HALF/2) scl_o = 1'b1;
            #HALF scl_o = 1'b0;
        end
        #(HALF/2) sda_low_o = 1'b0;
        #(HALF/2) scl_o = 1'b1;
        ack = !sda_i;
        #HALF scl_o = 1'b0;
    endtask
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            #HALF scl_o = 1'b1;
            b[i] = sda_i;
            #HALF scl_o = 1'b0;
        end
        // no acknowledge from us: the read ends after one byte
        #HALF scl_o = 1'b1;
        #HALF scl_o = 1'b0;
    endtask
    task automatic stop();
        #(HALF/2) sda_low_o = 1'b1;
        #(HALF/2) scl_o = 1'b1;
        #HALF sda_low_o = 1'b0;
        #HALF;
    endtask
    task automatic write_reg(input logic [6:0] addr, input logic [7:0] d, output logic ack);
        logic a2;
        start();
        put_byte({addr, 1'b0}, ack);
        if (ack)
        begin
            put_byte(d, a2);
            ack = a2;
        end
        stop();
    endtask
    task automatic read_reg(input logic [6:0] addr, output logic ack);
        logic [7:0] b;
        start();
        put_byte({addr, 1'b1}, ack);
        if (ack)
        begin
            get_byte(b);
            rd_data_o = b;
            rd_ev_o = 1'b1;
            #1 rd_ev_o = 1'b0;
        end
        stop();
    endtask
endmodule

/* File: verif/tb_top.sv */
// self-checking bench of the delay line control block
`timescale 1ns/100ps
module tb_top;
    import delay_ctrl_pkg::*;
    localparam int RSC = 8;
    logic                   clk_i = 1'b0;
    logic                   rst_b_i = 1'b1;
    logic                   buf_sel = 1'b0;
    logic [3:0]             straps = 4'h9;
    logic                   scl, sda_low, sda_o, sda_oe_b, resync, buf_diff, rd_ev;
    logic [4:0][5:0]        code;
    logic [4:0]             en;
    logic [1:0]             mode;
    logic [7:0]             rd_data;
    logic [7:0]             v [5];
    logic [7:0]             exp_q [$];
    logic [31:0]            seed, tmp;
    int                     fail_count = 0, n_compared = 0, run = 0, pulses = 0, i, p;
    wire                    sda_line = !(sda_low || (!sda_oe_b && !sda_o));
    initial forever #50 clk_i = ~clk_i;
    delay_line_i2c_control #(.RESYNC_CYCLES(RSC)) u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_b_o(sda_oe_b),
        .chip_address_straps_i(straps), .buffer_style_select_i(buf_sel),
        .delay_code_o(code), .chan_enable_o(en), .clk_mode_o(mode),
        .loop_resync_o(resync), .buffer_diff_o(buf_diff));
    i2c_master_model u_master (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda_line),
        .rd_data_o(rd_data), .rd_ev_o(rd_ev));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (fail_count == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [2:0] s, input logic [7:0] d,
                      input logic ea);
        logic ack;
        @(posedge clk_i);
        #2 u_master.write_reg({a, s}, d, ack);
        check("write ack", ack, ea);
        repeat (8) @(posedge clk_i);
    endtask
    task automatic rd(input logic [2:0] s, input logic [7:0] e);
        logic ack;
        exp_q.push_back(e);
        @(posedge clk_i);
        #2 u_master.read_reg({straps, s}, ack);
        check("read ack", ack, 1'b1);
    endtask
    // every read result is matched against the oldest expectation
    always @(posedge rd_ev)
        check("read data", rd_data, exp_q.pop_front());
    // the resync pulse length is measured whenever it ends
    always @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
            run = 0;
        else if (resync === 1'b1)
            run++;
        else if (run != 0)
        begin
            check("resync length", run, RSC);
            pulses++;
            run = 0;
        end
    initial
    begin
        #500000 fail_count++;
        report_and_stop();
    end
    initial
    begin
        seed = 32'hCF61;
        // a real falling edge, so the link-clocked flops reset before any frame
        #1 rst_b_i = 1'b0;
        repeat (10) @(posedge clk_i);
        #2 rst_b_i = 1'b1;
        repeat (3) @(posedge clk_i);
        check("code after reset", code, 30'h0);
        check("enable after reset", en, 5'h00);
        for (i = 0; i < 5; i++)
            rd(i[2:0], 8'h00);
        for (i = 0; i < 5; i++)
        begin
            tmp = $random(seed);
            v[i] = tmp[7:0];
            wr(straps, i[2:0], v[i], 1'b1);
            rd(i[2:0], v[i] & 8'h7F);
        end
        for (i = 0; i < 5; i++)
        begin
            check("delay code", code[i], v[i][5:0]);
            check("enable", en[i], v[i][6]);
        end
        wr(straps ^ 4'h1, 3'h0, ~v[0], 1'b0);
        check("foreign address", code[0], v[0][5:0]);
        for (i = 0; i < 4; i++)
        begin
            p = pulses;
            wr(straps, SEL_GLOBAL, {2'b01, 4'h0, i[1:0]}, 1'b1);
            rd(SEL_GLOBAL, {6'h00, i[1:0]});
            check("clock mode", mode, i[1:0]);
            check("resync pulses", pulses, p + 1);
        end
        wr(straps, 3'h6, 8'hFF, 1'b1);
        rd(3'h6, 8'h00);
        wr(straps, SEL_GLOBAL, 8'h82, 1'b1);
        check("chip reset enable", en, 5'h00);
        check("chip reset code", code, 30'h0);
        check("mode after chip reset", mode, 2'h2);
        wr(straps, 3'h1, 8'h7F, 1'b1);
        #2 rst_b_i = 1'b0;
        #5 check("pin reset enable", en, 5'h00);
        check("mode kept", mode, 2'h2);
        repeat (3) @(posedge clk_i);
        #2 rst_b_i = 1'b1;
        repeat (3) @(posedge clk_i);
        rd(3'h1, 8'h00);
        wr(straps, 3'h1, 8'h45, 1'b1);
        check("after release", {en[1], code[1]}, 7'h45);
        for (i = 0; i < 6; i++)
        begin
            @(posedge clk_i);
            tmp = $random(seed);
            #2 buf_sel = (i < 2) ? i[0] : tmp[0];
            repeat (3) @(posedge clk_i);
            check("buffer style", buf_diff, buf_sel);
        end
        check("reads left", exp_q.size(), 0);
        report_and_stop();
    end
endmodule
